// *** hdl/serial_eeprom_read_and_write_guard.sv ***
/*
  two-wire eeprom slave: link engine on link_clk, array on mclk.
  assumes scl_in/sda_in/wp/straps are pins, sda is open drain with
  external pull-up, and link_clk is much faster than scl.
*/
// How it works
// - guard high: writes never reach the array
// - guard high: all write bytes still acked
// - guard high: no programming at stop
// - guard low: whole array writable
// - pointer holds last accessed plus one, wrapping within the page after a write
// - read address: ack, then send pointer byte
// - word address bytes load the pointer
// - random read sends newly loaded location
// - nack then stop: release, go idle
// - master ack: send next sequential byte
// - sequential read ends on nack, stop
// - read pointer ignores page boundaries
// - pointer wraps from last to first
// - address: type, strap bits, direction bit
// - write word address high byte first
// - no address ack while programming
`include "eeprom_guard_regs.svh"
module serial_eeprom_read_and_write_guard #(
  parameter int         ADDR_W    = `EE_ADDR_W,
  parameter int         PAGE_W    = `EE_PAGE_W,
  parameter int         WR_CYCLES = `EE_T_WR_US * `EE_MCLK_MHZ,
  parameter logic [3:0] DEV_TYPE  = `EE_DEV_TYPE  // arbitrary value
) (
  input  wire logic       mclk,
  input  wire logic       ce,
  input  wire logic       srst,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output wire logic       sda_out,
  output wire logic       sda_oe,
  input  wire logic       write_guard,
  input  wire logic [2:0] chip_select_straps,
  output wire logic       prog_busy
);
  import eeprom_pkg::*;

  mem_port_if #(.ADDR_W(ADDR_W)) mp ();

  // array, staging and programming timer
  eeprom_array #(
    .ADDR_W    (ADDR_W),
    .PAGE_W    (PAGE_W),
    .WR_CYCLES (WR_CYCLES)
  ) u_array (
    .mclk (mclk),
    .ce   (ce),
    .srst (srst),
    .mp   (mp.array)
  );

  // pin and crossing synchronisers
  logic              rst_s1, rst_s2;     // reset into link domain
  logic              scl_s1, scl_s2;     // clock pin
  logic              sda_s1, sda_s2;     // data pin
  logic              wp_s1, wp_s2;       // write guard pin
  logic [2:0]        cs_s1, cs_s2;       // strap pins
  logic              ack_s1, ack_s2;     // array answer toggle
  logic              busy_s1, busy_s2;   // programming level
  logic              scl_d, sda_d;       // previous line levels
  logic              ack_d;              // previous answer toggle

  // link state
  link_state_e       state_reg, state_next;
  phase_e            phase_reg, phase_next;
  logic [2:0]        cnt_reg, cnt_next;     // bit counter
  logic [7:0]        sh_reg, sh_next;       // byte shifter
  logic              done_reg, done_next;   // byte or ack seen
  logic              oe_reg, oe_next;       // pulls sda low
  logic              rw_reg, rw_next;       // read direction
  logic [7:0]        hi_reg, hi_next;       // high address byte
  logic [ADDR_W-1:0] ptr_reg, ptr_next;     // word address pointer
  logic              wpend_reg, wpend_next; // data bytes staged
  logic              req_reg, req_next;     // request toggle
  mem_op_e           op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]        wd_reg, wd_next;
  logic [7:0]        rd_reg, rd_next;       // captured read answer

  // line events and decode
  logic              start_ev, stop_ev, rise, fall;
  logic              addr_hit;              // type and straps match
  logic              iss;                   // request this cycle
  mem_op_e           iss_op;
  logic [ADDR_W-1:0] iss_addr;
  logic [15:0]       word_addr;             // both address bytes

  assign start_ev  = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_ev   = scl_s2 && scl_d && !sda_d && sda_s2;
  assign rise      = scl_s2 && !scl_d;
  assign fall      = !scl_s2 && scl_d;
  assign word_addr = {hi_reg, sh_reg};
  // device type, strap bits, then direction bit
  assign addr_hit  = (sh_reg[`EE_TYPE_HI:`EE_TYPE_LO] == DEV_TYPE)
                  && (sh_reg[`EE_CS_HI:`EE_CS_LO] == cs_s2);
  assign sda_out   = 1'b0;
  assign sda_oe    = oe_reg;
  assign prog_busy = busy_s2;
  assign mp.req_tgl = req_reg;
  assign mp.op      = op_reg;
  assign mp.addr    = addr_reg;
  assign mp.wdata   = wd_reg;

  // two-flop synchronisers, then edge history
  always_ff @(posedge link_clk)
  begin
    rst_s1  <= srst;
    rst_s2  <= rst_s1;
    scl_s1  <= scl_in;
    scl_s2  <= scl_s1;
    sda_s1  <= sda_in;
    sda_s2  <= sda_s1;
    wp_s1   <= write_guard;
    wp_s2   <= wp_s1;
    cs_s1   <= chip_select_straps;
    cs_s2   <= cs_s1;
    ack_s1  <= mp.ack_tgl;
    ack_s2  <= ack_s1;
    busy_s1 <= mp.busy;
    busy_s2 <= busy_s1;
    scl_d   <= scl_s2;
    sda_d   <= sda_s2;
    ack_d   <= ack_s2;
  end

  // next state of the link engine
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    done_next  = done_reg;
    oe_next    = oe_reg;
    rw_next    = rw_reg;
    hi_next    = hi_reg;
    ptr_next   = ptr_reg;
    wpend_next = wpend_reg;
    wd_next    = wd_reg;
    rd_next    = rd_reg;
    iss        = 1'b0;
    iss_op     = OP_READ;
    iss_addr   = ptr_reg;
    // read answer taken once the toggle has crossed
    if (ack_s2 != ack_d)
      rd_next = mp.rdata;
    if (start_ev)
    begin
      // start or repeated start: a new address byte follows
      state_next = L_RX;
      phase_next = PH_ADDR;
      cnt_next   = 3'h0;
      done_next  = 1'b0;
      oe_next    = 1'b0;
      if (wpend_reg)
      begin
        iss        = 1'b1;
        iss_op     = OP_DISCARD;
        wpend_next = 1'b0;
      end
    end
    else if (stop_ev)
    begin
      // stop: release the line and return to standby
      state_next = L_IDLE;
      oe_next    = 1'b0;
      if (wpend_reg)
      begin
        // guard level at the stop picks commit or drop
        iss        = 1'b1;
        iss_op     = wp_s2 ? OP_DISCARD : OP_COMMIT;
        wpend_next = 1'b0;
      end
    end
    else
    begin
      unique case (state_reg)
        L_IDLE, L_WAIT_STOP: ;
        L_RX:
        begin
          // shift on rising clock, decide on the falling one
          if (rise)
          begin
            sh_next  = {sh_reg[6:0], sda_s2};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `EE_BIT_LAST)
              done_next = 1'b1;
          end
          if (fall && done_reg)
          begin
            done_next  = 1'b0;
            cnt_next   = 3'h0;
            state_next = L_RX_ACK;
            oe_next    = 1'b1;
            unique case (phase_reg)
              PH_ADDR:
              begin
                rw_next = sh_reg[`EE_RW_BIT];
                if (!addr_hit || busy_s2)
                begin
                  // not ours, or programming: stay silent
                  state_next = L_WAIT_STOP;
                  oe_next    = 1'b0;
                end
                else if (sh_reg[`EE_RW_BIT])
                begin
                  // fetch the byte at the pointer
                  iss      = 1'b1;
                  ptr_next = ptr_reg + 1'b1;
                end
              end
              PH_WHI: hi_next = sh_reg;
              PH_WLO: ptr_next = word_addr[ADDR_W-1:0];
              PH_DATA:
              begin
                // stage byte, pointer rolls within its page
                iss        = 1'b1;
                iss_op     = OP_STAGE;
                wd_next    = sh_reg;
                wpend_next = 1'b1;
                ptr_next   = {ptr_reg[ADDR_W-1:PAGE_W],
                              ptr_reg[PAGE_W-1:0] + 1'b1};
              end
            endcase
          end
        end
        L_RX_ACK:
        begin
          // end of acknowledge clock
          if (fall)
          begin
            if (rw_reg && phase_reg == PH_ADDR)
            begin
              state_next = L_TX;
              sh_next    = rd_reg;
              oe_next    = ~rd_reg[7];
            end
            else
            begin
              state_next = L_RX;
              oe_next    = 1'b0;
              unique case (phase_reg)
                PH_ADDR: phase_next = PH_WHI;
                PH_WHI:  phase_next = PH_WLO;
                PH_WLO, PH_DATA: phase_next = PH_DATA;
              endcase
            end
          end
        end
        L_TX:
        begin
          // next bit on each falling clock, msb first
          if (fall)
          begin
            if (cnt_reg == `EE_BIT_LAST)
            begin
              state_next = L_TX_ACK;
              oe_next    = 1'b0;
              cnt_next   = 3'h0;
            end
            else
            begin
              sh_next  = {sh_reg[6:0], 1'b0};
              oe_next  = ~sh_reg[6];
              cnt_next = cnt_reg + 3'h1;
            end
          end
        end
        L_TX_ACK:
        begin
          // master answer sampled on rising clock
          if (rise && !done_reg)
          begin
            if (sda_s2)
              state_next = L_WAIT_STOP;
            else
            begin
              // acked: fetch next byte, no page stop
              done_next = 1'b1;
              iss       = 1'b1;
              ptr_next  = ptr_reg + 1'b1;
            end
          end
          if (fall && done_reg)
          begin
            done_next  = 1'b0;
            state_next = L_TX;
            sh_next    = rd_reg;
            oe_next    = ~rd_reg[7];
          end
        end
      endcase
    end
    req_next  = iss ? ~req_reg : req_reg;
    op_next   = iss ? iss_op : op_reg;
    addr_next = iss ? iss_addr : addr_reg;
  end

  // register the link engine
  always_ff @(posedge link_clk)
  begin
    if (rst_s2)
    begin
      state_reg <= L_IDLE;
      phase_reg <= PH_ADDR;
      cnt_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      done_reg  <= 1'b0;
      oe_reg    <= 1'b0;
      rw_reg    <= 1'b0;
      hi_reg    <= 8'h00;
      ptr_reg   <= '0;
      wpend_reg <= 1'b0;
      req_reg   <= 1'b0;
      op_reg    <= OP_READ;
      addr_reg  <= '0;
      wd_reg    <= 8'h00;
      rd_reg    <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      done_reg  <= done_next;
      oe_reg    <= oe_next;
      rw_reg    <= rw_next;
      hi_reg    <= hi_next;
      ptr_reg   <= ptr_next;
      wpend_reg <= wpend_next;
      req_reg   <= req_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      rd_reg    <= rd_next;
    end
  end

  // checks on the link engine
  sequence s_byte_end;
    !start_ev && !stop_ev && state_reg == L_RX && fall && done_reg;
  endsequence
  sequence s_rd_addr;
    s_byte_end ##0 phase_reg == PH_ADDR && addr_hit && !busy_s2
      ##0 sh_reg[`EE_RW_BIT];
  endsequence
  sequence s_master_ack;
    !start_ev && !stop_ev && state_reg == L_TX_ACK && rise && !done_reg;
  endsequence
  sequence s_guarded_stop;
    stop_ev && wpend_reg;
  endsequence

  a_guard_drop: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_guarded_stop ##0 wp_s2 |=> op_reg == OP_DISCARD && req_reg != $past(req_reg))
    else $error("guarded write reached the array");
  a_guard_ack: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_byte_end ##0 phase_reg != PH_ADDR |=> oe_reg && state_reg == L_RX_ACK)
    else $error("write byte not acknowledged");
  a_guard_noprog: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_guarded_stop ##0 wp_s2 |=> op_reg != OP_COMMIT && !wpend_reg)
    else $error("programming started while guarded");
  a_open_commit: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_guarded_stop ##0 !wp_s2 |=> op_reg == OP_COMMIT && req_reg != $past(req_reg))
    else $error("unguarded write not committed");
  a_ptr_step: assert property (@(posedge link_clk) disable iff (rst_s2)
    iss && iss_op == OP_READ |=> ptr_reg == $past(ptr_reg) + 1'b1
      && addr_reg == $past(ptr_reg))
    else $error("pointer not last read plus one");
  a_read_ack: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_rd_addr |=> oe_reg && op_reg == OP_READ && state_reg == L_RX_ACK)
    else $error("read address not acknowledged");
  a_ptr_load: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_byte_end ##0 phase_reg == PH_WLO |=> ptr_reg == $past(word_addr[ADDR_W-1:0]))
    else $error("pointer not loaded from word address");
  a_tx_load: assert property (@(posedge link_clk) disable iff (rst_s2)
    $rose(state_reg == L_TX) |-> sh_reg == $past(rd_reg) && oe_reg == ~sh_reg[7])
    else $error("sent byte is not the fetched byte");
  a_nack_end: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_master_ack ##0 sda_s2 |=> state_reg == L_WAIT_STOP && !oe_reg [*2])
    else $error("line not released after nack");
  a_seq_next: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_master_ack ##0 !sda_s2 |=> op_reg == OP_READ && req_reg != $past(req_reg))
    else $error("no next byte after master ack");
  a_stop_idle: assert property (@(posedge link_clk) disable iff (rst_s2)
    stop_ev |=> state_reg == L_IDLE && !oe_reg)
    else $error("stop did not end transaction");
  a_ptr_wrap: assert property (@(posedge link_clk) disable iff (rst_s2)
    iss && iss_op == OP_READ && (&ptr_reg) |=> ptr_reg == '0)
    else $error("pointer did not wrap to zero");
  a_busy_quiet: assert property (@(posedge link_clk) disable iff (rst_s2)
    s_byte_end ##0 phase_reg == PH_ADDR && busy_s2 |=> !oe_reg [*3])
    else $error("address acked while programming");
endmodule

// *** hdl/eeprom_guard_regs.svh ***
/*
  constants of the serial eeprom read path and write guard:
  array and page sizes, slave address fields, write cycle timing.
  assumes it is included by bare name from each file that uses its constants.
*/
`ifndef EEPROM_GUARD_REGS_SVH
`define EEPROM_GUARD_REGS_SVH

// address pointer width (32768 bytes) and page index width (64 bytes)
`define EE_ADDR_W     15
`define EE_PAGE_W     6
// slave address byte fields
`define EE_TYPE_HI    7
`define EE_TYPE_LO    4
`define EE_CS_HI      3
`define EE_CS_LO      1
`define EE_RW_BIT     0
// device type code: value is arbitrary
`define EE_DEV_TYPE   4'h5
// last bit index of a byte
`define EE_BIT_LAST   3'h7
// write cycle time in microseconds and main clock rate in mhz
`define EE_T_WR_US    5000
`define EE_MCLK_MHZ   25

`endif

// *** hdl/eeprom_pkg.sv ***
/*
  types shared by the link engine and the array.
  assumes nothing of its surroundings.
*/
package eeprom_pkg;
  // link engine states
  typedef enum {L_IDLE, L_RX, L_RX_ACK, L_TX, L_TX_ACK, L_WAIT_STOP} link_state_e;
  // byte position inside a transaction
  typedef enum {PH_ADDR, PH_WHI, PH_WLO, PH_DATA} phase_e;
  // requests carried to the array
  typedef enum logic [1:0] {OP_READ, OP_STAGE, OP_COMMIT, OP_DISCARD} mem_op_e;
endpackage

// *** hdl/mem_port_if.sv ***
/*
  request/answer carrier between the link engine and the array.
  assumes a toggle handshake: fields stand still while req_tgl and ack_tgl differ.
*/
interface mem_port_if #(parameter int ADDR_W = 15);
  import eeprom_pkg::*;
  logic                req_tgl;  // flips once per request
  mem_op_e             op;       // request kind
  logic [ADDR_W-1:0]   addr;     // byte address
  logic [7:0]          wdata;    // staged data
  logic                ack_tgl;  // follows req_tgl when done
  logic [7:0]          rdata;    // read answer
  logic                busy;     // programming in progress
  modport link  (output req_tgl, op, addr, wdata, input ack_tgl, rdata, busy);
  modport array (input req_tgl, op, addr, wdata, output ack_tgl, rdata, busy);
endinterface

// *** hdl/eeprom_array.sv ***
/*
  byte array, page staging buffer and programming timer on mclk.
  assumes requests arrive from another clock by toggle handshake.
*/
`include "eeprom_guard_regs.svh"
module eeprom_array #(
  parameter int ADDR_W    = `EE_ADDR_W,
  parameter int PAGE_W    = `EE_PAGE_W,
  parameter int WR_CYCLES = `EE_T_WR_US * `EE_MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic srst,
  mem_port_if.array mp
);
  import eeprom_pkg::*;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGES = 1 << PAGE_W;
  localparam int TW    = $clog2(WR_CYCLES + 1);

  logic [7:0]              mem [DEPTH];      // array storage
  logic [7:0]              pbuf [PAGES];     // page staging
  logic                    req_s1_reg;       // sync stage one
  logic                    req_s2_reg;       // sync stage two
  logic                    seen_reg, seen_next;
  logic                    ack_reg, ack_next;
  logic [7:0]              rd_reg, rd_next;
  logic                    busy_reg, busy_next;
  logic [TW-1:0]           tmr_reg, tmr_next;
  logic [PAGES-1:0]        pval_reg, pval_next;
  logic [ADDR_W-PAGE_W-1:0] base_reg, base_next;
  logic                    new_req;          // fresh request seen
  logic                    commit_now;       // last timer cycle

  assign new_req    = req_s2_reg ^ seen_reg;
  assign commit_now = busy_reg && (tmr_reg == TW'(1));
  assign mp.ack_tgl = ack_reg;
  assign mp.rdata   = rd_reg;
  assign mp.busy    = busy_reg;

  // request toggle synchroniser
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
    end
    else if (ce)
    begin
      req_s1_reg <= mp.req_tgl;
      req_s2_reg <= req_s1_reg;
    end
  end

  // next state of handshake, timer and page valid bits
  always_comb
  begin
    seen_next = seen_reg;
    ack_next  = ack_reg;
    rd_next   = rd_reg;
    busy_next = busy_reg;
    tmr_next  = tmr_reg;
    pval_next = pval_reg;
    base_next = base_reg;
    if (busy_reg)
    begin
      // count down, then release the write
      tmr_next = tmr_reg - TW'(1);
      if (commit_now)
      begin
        busy_next = 1'b0;
        pval_next = '0;
      end
    end
    if (new_req)
    begin
      seen_next = req_s2_reg;
      ack_next  = ~ack_reg;
      unique case (mp.op)
        OP_READ:    rd_next = mem[mp.addr];
        OP_STAGE:
        begin
          pval_next[mp.addr[PAGE_W-1:0]] = 1'b1;
          base_next = mp.addr[ADDR_W-1:PAGE_W];
        end
        // programming starts only when something is staged
        OP_COMMIT:
        begin
          if (|pval_reg && !busy_reg)
          begin
            busy_next = 1'b1;
            tmr_next  = TW'(WR_CYCLES);
          end
        end
        OP_DISCARD: pval_next = '0;
      endcase
    end
  end

  // register handshake, timer and page state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      seen_reg <= 1'b0;
      ack_reg  <= 1'b0;
      rd_reg   <= 8'h00;
      busy_reg <= 1'b0;
      tmr_reg  <= '0;
      pval_reg <= '0;
      base_reg <= '0;
    end
    else if (ce)
    begin
      seen_reg <= seen_next;
      ack_reg  <= ack_next;
      rd_reg   <= rd_next;
      busy_reg <= busy_next;
      tmr_reg  <= tmr_next;
      pval_reg <= pval_next;
      base_reg <= base_next;
    end
  end

  // storage writes: staging and end of programming
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (new_req && mp.op == OP_STAGE)
        pbuf[mp.addr[PAGE_W-1:0]] <= mp.wdata;
      if (commit_now)
        for (int i = 0; i < PAGES; i++)
          if (pval_reg[i])
            mem[{base_reg, PAGE_W'(i)}] <= pbuf[i];
    end
  end
endmodule

// *** bench/bus_master_model.sv ***
/*
  two-wire bus master model: drives the clock and pulls data low.
  assumes sda is resolved outside with a pull-up to high.
*/
module bus_master_model (
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 500; // half bit time, slow versus both clocks
  // idle bus: clock stands high, data released
  initial
  begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    pull = 1'b0;
    #H scl = 1'b1;
    #H pull = 1'b1;
    #H scl = 1'b0;
  endtask
  // stop: data rises while clock high, then clock stands still
  task automatic stop();
    pull = 1'b1;
    #H scl = 1'b1;
    #H pull = 1'b0;
    #H;
  endtask
  // eight bits msb first, then ninth bit; data moves only while clock low
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic r9);
    for (int i = 7; i >= 0; i--)
    begin
      pull = ~d[i];
      #H scl = 1'b1;
      #H q[i] = sda;
      scl = 1'b0;
    end
    pull = ~b9;
    #H scl = 1'b1;
    #H r9 = sda;
    scl = 1'b0;
  endtask
endmodule

// *** bench/serial_eeprom_read_and_write_guard_tb_top.sv ***
/*
  self-checking bench: writes, guarded writes, reads and wrap.
  assumes the bus master model and the design files alongside.
*/
`include "eeprom_guard_regs.svh"
module serial_eeprom_read_and_write_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'b0, link_clk = 1'b0, srst = 1'b1, write_guard = 1'b0;
  logic [2:0] chip_select_straps = 3'h5;
  wire logic  scl, pull, sda_out, sda_oe, prog_busy;
  wire logic  sda = ~((sda_oe & ~sda_out) | pull); // open drain, pull-up
  logic [7:0] q;
  logic       a;
  int         bad_count = 0, n_compared = 0;
  localparam logic [6:0] DEV = {`EE_DEV_TYPE, 3'h5};
  initial forever #20 mclk = ~mclk;
  // link clock offset so the two stay unrelated
  initial
  begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  serial_eeprom_read_and_write_guard #(.WR_CYCLES(1000)) uut (
    .mclk(mclk), .ce(1'b1), .srst(srst), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .write_guard(write_guard),
    .chip_select_straps(chip_select_straps), .prog_busy(prog_busy));
  bus_master_model m (.sda(sda), .scl(scl), .pull(pull));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // start, write address, both word address bytes, all acked
  task automatic addr_ph(input logic [15:0] ad);
    m.start();
    m.xfer({DEV, 1'b0}, 1'b1, q, a);
    chk(a, 0);
    m.xfer(ad[15:8], 1'b1, q, a);
    chk(a, 0);
    m.xfer(ad[7:0], 1'b1, q, a);
    chk(a, 0);
  endtask
  // bounded wait for programming; poll refused while busy
  task automatic busy_wait(input logic exp);
    int i;
    i = 0;
    while (prog_busy !== 1'b1 && i < 300)
    begin
      @(posedge mclk);
      i++;
    end
    chk(prog_busy, exp);
    if (exp)
    begin
      m.start();
      m.xfer({DEV, 1'b0}, 1'b1, q, a);
      chk(a, 1);
      m.stop();
    end
    i = 0;
    while (prog_busy !== 1'b0 && i < 3000)
    begin
      @(posedge mclk);
      i++;
    end
    if (i >= 3000)
    begin
      bad_count++;
      finish_test();
    end
  endtask
  // write one or two bytes then stop
  task automatic wr(input logic [15:0] ad, input logic [7:0] d0, input logic [7:0] d1,
                    input logic two, input logic prot);
    addr_ph(ad);
    m.xfer(d0, 1'b1, q, a);
    chk(a, 0);
    if (two)
    begin
      m.xfer(d1, 1'b1, q, a);
      chk(a, 0);
    end
    m.stop();
    busy_wait(!prot);
  endtask
  // dummy write plus repeated start, or current address; one or two bytes
  task automatic rd(input logic [15:0] ad, input logic rnd, input logic [7:0] e0,
                    input logic [7:0] e1, input logic two);
    if (rnd)
      addr_ph(ad);
    m.start();
    m.xfer({DEV, 1'b1}, 1'b1, q, a);
    chk(a, 0);
    m.xfer(8'hFF, !two, q, a);
    chk(q, e0);
    if (two)
    begin
      m.xfer(8'hFF, 1'b1, q, a);
      chk(q, e1);
    end
    m.stop();
    chk(sda_oe, 0);
  endtask
  task automatic t_guard();
    @(posedge mclk) write_guard <= 1'b1;
    wr(16'h0123, 8'hFF, 8'h00, 1'b1, 1'b1);
    rd(16'h0123, 1'b1, 8'h5A, 8'h96, 1'b1);
    @(posedge mclk) write_guard <= 1'b0;
  endtask
  task automatic t_straps();
    m.start();
    m.xfer({`EE_DEV_TYPE, 3'h2, 1'b1}, 1'b1, q, a);
    chk(a, 1);
    m.stop();
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    chk(sda_oe, 0);
    chk(prog_busy, 0);
    repeat (4) @(posedge mclk);
    wr(16'h0123, 8'h5A, 8'h96, 1'b1, 1'b0);
    rd(16'h0123, 1'b1, 8'h5A, 8'h00, 1'b0);
    rd(16'h0000, 1'b0, 8'h96, 8'h00, 1'b0);
    t_guard();
    wr(16'h7FFF, 8'hA5, 8'h00, 1'b0, 1'b0);
    wr(16'h0000, 8'h3C, 8'h00, 1'b0, 1'b0);
    rd(16'hFFFF, 1'b1, 8'hA5, 8'h3C, 1'b1);
    t_straps();
    finish_test();
  end
endmodule
